//--- core/asw_defs.vh
// Constants for the host-side controller of the asynchronous word/byte memory.
// Assumes a 40 MHz system clock (25 ns period); all counts derive from it.
`ifndef ASW_DEFS_VH
`define ASW_DEFS_VH

`define ASW_CLK_PERIOD_NS    25
`define ASW_ADDR_W           19
`define ASW_DATA_W           16

// Grade 0 is the 55 ns part, grade 1 the 70 ns part.
`define ASW_RC_NS_G0         55
`define ASW_RC_NS_G1         70
`define ASW_AA_NS_G0         55
`define ASW_AA_NS_G1         70
`define ASW_WC_NS_G0         55
`define ASW_WC_NS_G1         70
`define ASW_WP_NS_G0         40
`define ASW_WP_NS_G1         55
`define ASW_CW_NS_G0         45
`define ASW_CW_NS_G1         60
`define ASW_DW_NS_G0         20
`define ASW_DW_NS_G1         30
`define ASW_HZ_NS_G0         20
`define ASW_HZ_NS_G1         25
`define ASW_WR_NS            0
`define ASW_AS_NS            0
`define ASW_DH_NS            0
`define ASW_RDR_MS           5

// Least times round up to whole cycles, never below one.
`define ASW_CEIL(ns)   ((((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS) < 1 ? 1 : \
                        (((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS))
`define ASW_RDR_CYC    ((`ASW_RDR_MS * 1000000 + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS)

`endif

//--- core/asw_sync2.v
// Two-flop synchroniser for pin inputs, WIDTH bits wide.
// Assumes the data is stable long enough to be sampled by clk_sys_i.
`timescale 1ns/100ps
module asw_sync2 #(
    parameter WIDTH = 16
) (
    input  wire             clk_sys_i,
    input  wire             reset_n_i,
    input  wire             clk_en_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1 <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else if (clk_en_i) begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // asw_sync2

//--- core/asw_ctrl.v
// Host controller that drives an asynchronous 512K x 16 memory through its pins.
// Assumes one request port on clk_sys_i and the memory data bus resolved outside.
// Accesses are never pipelined: throughput is one word per access cycle plus the
// float gap, which was traded for a controller that cannot clash on the bus.
//
// Behaviour
// - Host holds every pin at valid level; the host drives the data pins only during writes.
// - Write spans select and strobe low overlap.
// - Write pulse 40 ns, cycle 55 ns.
// - Select, address, lanes 45 ns before end.
// - Data 20 ns before end, zero hold.
// - Address valid by write start.
// - Address may change at write end.
// - 70 ns grade uses longer limits.
// - Hold select high; wait 5 ms after recovery.
`timescale 1ns/100ps
`include "asw_defs.vh"
module asw_ctrl #(
    parameter ADDR_W  = `ASW_ADDR_W,
    parameter DATA_W  = `ASW_DATA_W,
    parameter GRADE70 = 0,
    parameter RDR_CYC = `ASW_RDR_CYC
) (
    input  wire              clk_sys_i,
    input  wire              reset_n_i,
    input  wire              clk_en_i,
    input  wire              retain_i,
    input  wire              req_valid_i,
    input  wire              req_write_i,
    input  wire [ADDR_W-1:0] req_addr_i,
    input  wire [DATA_W-1:0] req_wdata_i,
    input  wire [1:0]        req_lanes_i,
    output reg               req_ready_o,
    output reg               rsp_valid_o,
    output reg  [DATA_W-1:0] rsp_rdata_o,
    output reg               ready_o,
    output reg  [ADDR_W-1:0] word_address_o,
    output reg               select_n_o,
    output reg               output_gate_n_o,
    output reg               write_strobe_n_o,
    output reg               low_lane_n_o,
    output reg               high_lane_n_o,
    input  wire [DATA_W-1:0] data_bus_i,
    output reg  [DATA_W-1:0] data_bus_o,
    output reg               data_bus_oe_n_o
);
    // Pin-referenced timing in clock cycles, grade chosen by parameter.
    // Every least time is rounded up to whole cycles, so a slower system clock only
    // lengthens accesses; it never cuts a minimum that the memory needs.
    localparam integer RD_CYC  = GRADE70 ? `ASW_CEIL(`ASW_AA_NS_G1) : `ASW_CEIL(`ASW_AA_NS_G0);
    localparam integer SYN_CYC = 2;
    localparam integer WP_CYC  = GRADE70 ? `ASW_CEIL(`ASW_CW_NS_G1) : `ASW_CEIL(`ASW_CW_NS_G0);
    localparam integer HZ_CYC  = GRADE70 ? `ASW_CEIL(`ASW_HZ_NS_G1) : `ASW_CEIL(`ASW_HZ_NS_G0);
    localparam integer RC_CYC  = GRADE70 ? `ASW_CEIL(`ASW_RC_NS_G1) : `ASW_CEIL(`ASW_RC_NS_G0);
    localparam integer WC_CYC  = GRADE70 ? `ASW_CEIL(`ASW_WC_NS_G1) : `ASW_CEIL(`ASW_WC_NS_G0);
    localparam integer WPS_CYC = GRADE70 ? `ASW_CEIL(`ASW_WP_NS_G1) : `ASW_CEIL(`ASW_WP_NS_G0);
    localparam integer DW_CYC  = GRADE70 ? `ASW_CEIL(`ASW_DW_NS_G1) : `ASW_CEIL(`ASW_DW_NS_G0);
    localparam integer WLOW    = (WP_CYC > WPS_CYC) ? WP_CYC : WPS_CYC;
    localparam integer WLOW2   = (WLOW > DW_CYC) ? WLOW : DW_CYC;
    // Wide enough for the recovery count at 40 MHz; a faster clock may need more bits.
    localparam integer CNT_W   = 24;

    localparam [2:0] ST_RECOV = 3'h0;
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_READ  = 3'h2;
    localparam [2:0] ST_WRITE = 3'h3;
    localparam [2:0] ST_GAP   = 3'h4;
    localparam [2:0] ST_RET   = 3'h5;

    reg  [2:0]       state;
    reg  [2:0]       next_state;
    reg  [CNT_W-1:0] cnt;
    reg  [CNT_W-1:0] next_cnt;
    reg              was_write;
    wire [DATA_W-1:0] rd_sync;

    // Read data leaves the memory's timing domain, so it is synchronised first.
    asw_sync2 #(.WIDTH(DATA_W)) u_rd_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .async_i   (data_bus_i),
        .sync_o    (rd_sync)
    );

    always @* begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ST_RECOV: begin
                // Accesses resume only after the retention recovery time.
                if (retain_i) begin
                    next_state = ST_RET;
                end else if (cnt >= RDR_CYC[CNT_W-1:0]) begin
                    next_state = ST_IDLE;
                    next_cnt   = {CNT_W{1'b0}};
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_IDLE: begin
                // Retention wins over a request, so select never falls while
                // the supply is about to drop.
                if (retain_i) begin
                    next_state = ST_RET;
                end else if (req_valid_i) begin
                    next_state = req_write_i ? ST_WRITE : ST_READ;
                    next_cnt   = {CNT_W{1'b0}};
                end
            end
            ST_READ: begin
                // Data sampled after access time plus synchroniser latency.
                // The two synchroniser cycles are paid on every read because the
                // memory answers on no clock of ours.
                if (cnt >= RD_CYC[CNT_W-1:0] + SYN_CYC[CNT_W-1:0]) begin
                    next_state = ST_GAP;
                    next_cnt   = {CNT_W{1'b0}};
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_WRITE: begin
                // Overlap held for the longest of pulse, select and data set-up.
                if (cnt >= WLOW2[CNT_W-1:0] - 1'b1) begin
                    next_state = ST_GAP;
                    next_cnt   = {CNT_W{1'b0}};
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_GAP: begin
                // Float time and cycle time pass before the next access.
                // Waiting out the float time keeps two drivers off the bus at once.
                if (cnt >= HZ_CYC[CNT_W-1:0] +
                        (was_write ? WC_CYC[CNT_W-1:0] : RC_CYC[CNT_W-1:0])) begin
                    next_state = ST_IDLE;
                    next_cnt   = {CNT_W{1'b0}};
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_RET: begin
                // Select stays high while supply is low.
                if (!retain_i) begin
                    next_state = ST_RECOV;
                    next_cnt   = {CNT_W{1'b0}};
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt   = {CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state            <= ST_RECOV;
            cnt              <= {CNT_W{1'b0}};
            was_write        <= 1'b0;
            req_ready_o      <= 1'b0;
            rsp_valid_o      <= 1'b0;
            rsp_rdata_o      <= {DATA_W{1'b0}};
            ready_o          <= 1'b0;
            word_address_o   <= {ADDR_W{1'b0}};
            select_n_o       <= 1'b1;
            output_gate_n_o  <= 1'b1;
            write_strobe_n_o <= 1'b1;
            low_lane_n_o     <= 1'b1;
            high_lane_n_o    <= 1'b1;
            data_bus_o       <= {DATA_W{1'b0}};
            data_bus_oe_n_o  <= 1'b1;
        end else if (clk_en_i) begin
            state       <= next_state;
            cnt         <= next_cnt;
            rsp_valid_o <= 1'b0;
            ready_o     <= (next_state == ST_IDLE);
            req_ready_o <= (next_state == ST_IDLE) && !retain_i;
            if (state == ST_IDLE && next_state != ST_IDLE && next_state != ST_RET) begin
                // Address, lanes and data set up together with the start.
                was_write        <= req_write_i;
                req_ready_o      <= 1'b0;
                word_address_o   <= req_addr_i;
                select_n_o       <= 1'b0;
                low_lane_n_o     <= ~req_lanes_i[0];
                high_lane_n_o    <= ~req_lanes_i[1];
                output_gate_n_o  <= req_write_i;
                write_strobe_n_o <= ~req_write_i;
                data_bus_o       <= req_wdata_i;
                data_bus_oe_n_o  <= ~req_write_i;
            end else if (state == ST_READ && next_state == ST_GAP) begin
                rsp_rdata_o     <= rd_sync;
                rsp_valid_o     <= 1'b1;
                select_n_o      <= 1'b1;
                output_gate_n_o <= 1'b1;
                low_lane_n_o    <= 1'b1;
                high_lane_n_o   <= 1'b1;
            end else if (state == ST_WRITE && next_state == ST_GAP) begin
                // Strobe and select rise together; data is released a cycle later
                // which costs nothing since hold is zero.
                select_n_o       <= 1'b1;
                write_strobe_n_o <= 1'b1;
                low_lane_n_o     <= 1'b1;
                high_lane_n_o    <= 1'b1;
                rsp_valid_o      <= 1'b1;
            end else if (state == ST_GAP) begin
                data_bus_oe_n_o <= 1'b1;
            end
        end
    end
endmodule // asw_ctrl

//--- tb/asw_ctrl_chk.sv
// Pin checker for the memory host controller.
// Assumes binding to asw_ctrl with the same RDR_CYC.
`timescale 1ns/100ps
module asw_ctrl_chk #(
    parameter RDR_CYC = 4
) (
    input wire        clk_sys_i,
    input wire        reset_n_i,
    input wire        clk_en_i,
    input wire        retain_i,
    input wire        req_valid_i,
    input wire        req_write_i,
    input wire        req_ready_o,
    input wire        rsp_valid_o,
    input wire [18:0] word_address_o,
    input wire        select_n_o,
    input wire        output_gate_n_o,
    input wire        write_strobe_n_o,
    input wire        low_lane_n_o,
    input wire        high_lane_n_o,
    input wire        data_bus_oe_n_o
);
    reg [31:0] since;
    always @(posedge clk_sys_i or negedge reset_n_i)
        if (!reset_n_i) since <= 32'h0;
        else if (clk_en_i && since <= RDR_CYC) since <= since + 32'h1;
    default clocking cb @(posedge clk_sys_i); endclocking
    // A frozen clock enable stretches every count, so it suspends the checks.
    default disable iff (!reset_n_i || !clk_en_i);
    sequence wr_start; $fell(write_strobe_n_o); endsequence
    sequence rd_take; req_valid_i && req_ready_o && !retain_i && !req_write_i; endsequence
    sequence wr_hold; !select_n_o ##1 (!select_n_o && $stable(word_address_o)); endsequence
    strobe_pulse_a: assert property (wr_start |-> !write_strobe_n_o[*2])
        else $error("write pulse short");
    write_hold_a: assert property (wr_start |-> wr_hold)
        else $error("select or address moved in write");
    data_end_a: assert property ($rose(write_strobe_n_o) |-> !data_bus_oe_n_o)
        else $error("data gone before write end");
    bus_clash_a: assert property (!data_bus_oe_n_o |-> output_gate_n_o)
        else $error("host drives while gate open");
    write_lane_a: assert property (!write_strobe_n_o |-> !select_n_o && !(low_lane_n_o && high_lane_n_o))
        else $error("strobe without select or lane");
    read_len_a: assert property ($fell(output_gate_n_o) |-> !output_gate_n_o[*3])
        else $error("read cycle short");
    rd_answer_a: assert property (rd_take |-> ##7 rsp_valid_o)
        else $error("read answer late");
    retain_a: assert property (retain_i && req_ready_o |=> select_n_o)
        else $error("select low in retention");
    recovery_a: assert property (req_ready_o |-> since > RDR_CYC)
        else $error("ready before recovery");
endmodule // asw_ctrl_chk
bind asw_ctrl asw_ctrl_chk #(.RDR_CYC(RDR_CYC)) u_chk (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .retain_i(retain_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .word_address_o(word_address_o), .select_n_o(select_n_o), .output_gate_n_o(output_gate_n_o),
    .write_strobe_n_o(write_strobe_n_o), .low_lane_n_o(low_lane_n_o),
    .high_lane_n_o(high_lane_n_o), .data_bus_oe_n_o(data_bus_oe_n_o));

//--- tb/asw_mem_model.sv
// Behavioural asynchronous 512K x 16 memory.
// Assumes the bench resolves the shared data bus and feeds it back.
`timescale 1ns/100ps
module asw_mem_model (
    input  wire        slow_i,
    input  wire [18:0] word_address_i,
    input  wire        select_n_i,
    input  wire        output_gate_n_i,
    input  wire        write_strobe_n_i,
    input  wire        low_lane_n_i,
    input  wire        high_lane_n_i,
    input  wire [15:0] data_bus_i,
    output wire [15:0] data_bus_o,
    output wire [1:0]  drive_o
);
    logic [15:0] mem [0:(1<<19)-1];
    wire [1:0]  live = {2{!select_n_i && !output_gate_n_i && write_strobe_n_i}}
                       & ~{high_lane_n_i, low_lane_n_i};
    wire [1:0]  on_f, on_s, wl;
    wire [15:0] wd;
    wire [18:0] wa;
    wire        ws, wt;
    assign #15 on_f = live;
    assign #50 on_s = live;
    // Turn-off is instant, so it can never overlap a later driver.
    assign drive_o = live & (slow_i ? on_s : on_f);
    assign #10 data_bus_o = mem[word_address_i];
    // Pins as they stood just before the write ended.
    assign #1 {wa, wl, wd, ws, wt} = {word_address_i, ~{high_lane_n_i, low_lane_n_i},
                                      data_bus_i, select_n_i, write_strobe_n_i};
    always @(posedge select_n_i or posedge write_strobe_n_i)
        if (!ws && !wt) begin
            if (wl[0]) mem[wa][7:0] = wd[7:0];
            if (wl[1]) mem[wa][15:8] = wd[15:8];
        end
endmodule // asw_mem_model

//--- tb/async_sram_word_byte_port_tb.sv
// Self-checking bench: controller against the memory model.
// Assumes design, checker and model are compiled before it.
`timescale 1ns/100ps
module async_sram_word_byte_port_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         en = 1'b1;
    reg         ret = 1'b0;
    reg         vld = 1'b0;
    reg         wr = 1'b0;
    reg         slow = 1'b0;
    reg         g70 = 1'b0;
    reg  [18:0] addr = 19'h0;
    reg  [15:0] wdat = 16'h0;
    reg  [1:0]  lanes = 2'h0;
    reg  [15:0] junk = 16'h5A3C;
    reg  [15:0] shadow [0:7];
    reg  [31:0] r;
    reg  [1:0]  ln;
    wire        rdy, rsp, idle, sel_n, gate_n, stb_n, ll_n, hl_n, oe_n;
    wire [15:0] rdata, dq, md, bus;
    wire [18:0] adr;
    wire [1:0]  mdrv;
    wire        rdy2, rsp2, idle2, sel2_n, gate2_n, stb2_n, ll2_n, hl2_n, oe2_n;
    wire [15:0] rdata2, dq2, md2, bus2;
    wire [18:0] adr2;
    wire [1:0]  mdrv2;
    integer     seed = 32'hDBCB6282;
    integer     miscompares = 0;
    integer     n_tests = 0;
    integer     i, k;
    always #12.5 clk = ~clk;
    // Lanes nobody drives show a value that moves every cycle.
    always @(posedge clk) junk <= junk + 16'h3B5D;
    assign bus = !oe_n ? dq : {mdrv[1] ? md[15:8] : junk[15:8], mdrv[0] ? md[7:0] : junk[7:0]};
    assign bus2 = !oe2_n ? dq2 : {mdrv2[1] ? md2[15:8] : junk[15:8],
                                  mdrv2[0] ? md2[7:0] : junk[7:0]};
    asw_ctrl #(.RDR_CYC(4)) DUT (.clk_sys_i(clk), .reset_n_i(rst_n), .clk_en_i(en),
        .retain_i(ret), .req_valid_i(vld & !g70), .req_write_i(wr), .req_addr_i(addr),
        .req_wdata_i(wdat), .req_lanes_i(lanes), .req_ready_o(rdy), .rsp_valid_o(rsp),
        .rsp_rdata_o(rdata), .ready_o(idle), .word_address_o(adr), .select_n_o(sel_n),
        .output_gate_n_o(gate_n), .write_strobe_n_o(stb_n), .low_lane_n_o(ll_n),
        .high_lane_n_o(hl_n), .data_bus_i(bus), .data_bus_o(dq), .data_bus_oe_n_o(oe_n));
    asw_mem_model u_mem (.slow_i(slow), .word_address_i(adr), .select_n_i(sel_n),
        .output_gate_n_i(gate_n), .write_strobe_n_i(stb_n), .low_lane_n_i(ll_n),
        .high_lane_n_i(hl_n), .data_bus_i(bus), .data_bus_o(md), .drive_o(mdrv));
    // The slower grade runs on its own memory and takes requests only while g70 is high.
    asw_ctrl #(.RDR_CYC(4), .GRADE70(1)) DUT_G70 (.clk_sys_i(clk), .reset_n_i(rst_n),
        .clk_en_i(en), .retain_i(ret), .req_valid_i(vld & g70), .req_write_i(wr),
        .req_addr_i(addr), .req_wdata_i(wdat), .req_lanes_i(lanes), .req_ready_o(rdy2),
        .rsp_valid_o(rsp2), .rsp_rdata_o(rdata2), .ready_o(idle2), .word_address_o(adr2),
        .select_n_o(sel2_n), .output_gate_n_o(gate2_n), .write_strobe_n_o(stb2_n),
        .low_lane_n_o(ll2_n), .high_lane_n_o(hl2_n), .data_bus_i(bus2), .data_bus_o(dq2),
        .data_bus_oe_n_o(oe2_n));
    asw_mem_model u_mem70 (.slow_i(slow), .word_address_i(adr2), .select_n_i(sel2_n),
        .output_gate_n_i(gate2_n), .write_strobe_n_i(stb2_n), .low_lane_n_i(ll2_n),
        .high_lane_n_i(hl2_n), .data_bus_i(bus2), .data_bus_o(md2), .drive_o(mdrv2));
    wire        rdy_sel = g70 ? rdy2 : rdy;
    wire        rsp_sel = g70 ? rsp2 : rsp;
    wire [15:0] rdata_sel = g70 ? rdata2 : rdata;
    function [15:0] lm(input [1:0] l);
        lm = {{8{l[1]}}, {8{l[0]}}};
    endfunction
    task check(input [15:0] act, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (act !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h, expected %h", $time, act, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task wait_sig(input w_rsp);
        begin
            k = 0;
            while (k < 60 && (w_rsp ? rsp_sel : rdy_sel) !== 1'b1) begin
                @(negedge clk);
                k = k + 1;
            end
            if (k == 60) begin
                check(16'h1, 16'h0);
                test_done;
            end
        end
    endtask
    task access(input w, input [2:0] x, input [15:0] d, input [1:0] l, input frz);
        begin
            wait_sig(1'b0);
            {vld, wr, addr, wdat, lanes} = {1'b1, w, (x == 3'h7) ? 19'h7FFFF : {x, 16'h0}, d, l};
            @(negedge clk);
            vld = 1'b0;
            if (frz) begin
                en = 1'b0;
                repeat (3) @(negedge clk);
                check({14'h0, gate_n, stb_n}, {14'h0, w, ~w});
                en = 1'b1;
            end
            wait_sig(1'b1);
            if (w) shadow[x] = (shadow[x] & ~lm(l)) | (d & lm(l));
            else check(rdata_sel & lm(l), shadow[x] & lm(l));
        end
    endtask
    initial begin
        repeat (6) @(negedge clk);
        check({11'h0, sel_n, stb_n, gate_n, oe_n, idle}, 16'h1E);
        rst_n = 1'b1;
        wait_sig(1'b0);
        check({15'h0, k > 4}, 16'h1);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            access(1'b1, i[2:0], r[15:0], 2'h3, 1'b0);
        end
        for (i = 0; i < 80; i = i + 1) begin
            r = $random(seed);
            slow = r[22];
            ln = (r[21:20] == 2'h0) ? 2'h3 : r[21:20];
            access(r[0], r[3:1], r[19:4], ln, i == 40);
        end
        wait_sig(1'b0);
        {ret, vld} = 2'h3;
        repeat (8) begin
            @(negedge clk);
            check({10'h0, sel_n, sel2_n, rsp, rdy, idle, idle2}, 16'h30);
        end
        {ret, vld} = 2'h0;
        access(1'b0, 3'h7, 16'h0, 2'h3, 1'b0);
        g70 = 1'b1;
        for (i = 0; i < 24; i = i + 1) begin
            r = $random(seed);
            ln = (r[21:20] == 2'h0) ? 2'h3 : r[21:20];
            if (i < 8) access(1'b1, i[2:0], shadow[i], 2'h3, 1'b0);
            else access(r[0], r[3:1], r[19:4], ln, 1'b0);
        end
        test_done;
    end
endmodule // async_sram_word_byte_port_tb
